// *** core/irpwm_pkg.sv ***
// package: register map, field positions and reset values of the ir carrier / pwm generator
package irpwm_pkg;
    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] IRPWM_IR_CTRL_OFS   = 8'h00;
    localparam logic [7:0] IRPWM_CNT_CTRL_OFS  = 8'h04;
    localparam logic [7:0] IRPWM_PT_CTRL_OFS   = 8'h08;
    localparam logic [7:0] IRPWM_CAR_PRE_OFS   = 8'h0C;
    localparam logic [7:0] IRPWM_HI_PRE_OFS    = 8'h10;
    localparam logic [7:0] IRPWM_LO_PRE_OFS    = 8'h14;
    localparam logic [7:0] IRPWM_INT_STAT_OFS  = 8'h18;
    localparam logic [7:0] IRPWM_INT_MASK_OFS  = 8'h1C;
    localparam logic [7:0] IRPWM_STATUS_OFS    = 8'h20;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int IRPWM_IRE_BIT    = 0;   // infrared_output_enable
    localparam int IRPWM_HF_BIT     = 1;   // carrier_modulate_enable
    localparam int IRPWM_LGP_BIT    = 2;   // low_pulse_only_select
    localparam int IRPWM_CSEL_BIT   = 0;   // clock select: 0 main, 1 sub
    localparam int IRPWM_PSC_LSB    = 1;   // prescaler exponent, 3 bits
    localparam int IRPWM_PSC_W      = 3;
    localparam int IRPWM_EV_CAR     = 0;
    localparam int IRPWM_EV_HI      = 1;
    localparam int IRPWM_EV_LO      = 2;
    localparam int IRPWM_EV_N       = 3;
    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] IRPWM_CTRL_RST = 8'h00;
    localparam logic [7:0] IRPWM_PRE_RST  = 8'hFF;
    // ****************************************************************
    // bus responses
    // ****************************************************************
    localparam logic [1:0] IRPWM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] IRPWM_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {IRPWM_IDLE, IRPWM_HIGH, IRPWM_LOW} irpwm_phase_t;
endpackage

// *** core/irpwm_top.sv ***
// module: ir carrier / pwm generator with axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
module irpwm_top
    import irpwm_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                ce,
    input  wire logic                main_oscillator_clock,
    input  wire logic                sub_oscillator_clock,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic                     infrared_output_pin,
    output logic                     irq
);
    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0]             ir_ctrl_ff;
    logic [7:0]             cnt_ctrl_ff;
    logic [7:0]             pt_ctrl_ff;
    logic [7:0]             car_pre_ff;
    logic [7:0]             hi_pre_ff;
    logic [7:0]             lo_pre_ff;
    logic [IRPWM_EV_N-1:0]  int_stat_ff;
    logic [IRPWM_EV_N-1:0]  int_mask_ff;
    // ****************************************************************
    // axi state
    // ****************************************************************
    logic                   aw_held_ff;
    logic [ADDR_W-1:0]      aw_addr_ff;
    logic                   w_held_ff;
    logic [31:0]            w_data_ff;
    logic [3:0]             w_strb_ff;
    logic                   bvalid_ff;
    logic [1:0]             bresp_ff;
    logic                   rvalid_ff;
    logic [1:0]             rresp_ff;
    logic [31:0]            rdata_ff;
    logic                   wr_go;
    logic                   wr_hit;
    logic [7:0]             wr_ofs;
    logic [7:0]             rd_ofs;
    logic [31:0]            rd_val;
    logic                   rd_hit;
    // ****************************************************************
    // timing state
    // ****************************************************************
    logic [1:0]             osc_s1_ff;
    logic [1:0]             osc_s2_ff;
    logic [1:0]             osc_prev_ff;
    logic [1:0]             osc_edge;
    logic [6:0]             car_psc_ff;
    logic [6:0]             pt_psc_ff;
    logic                   car_tick;
    logic                   pt_tick;
    logic [7:0]             car_cnt_ff;
    logic                   car_wave_ff;
    logic [7:0]             hi_cnt_ff;
    logic [7:0]             lo_cnt_ff;
    logic                   lgp_tog_ff;
    irpwm_phase_t           phase_ff;
    irpwm_phase_t           nxt_phase;
    logic                   out_ff;
    logic                   nxt_out;
    logic                   car_uf;
    logic                   hi_uf;
    logic                   lo_uf;
    logic [IRPWM_EV_N-1:0]  ev;
    logic                   infrared_output_enable;
    logic                   hf;
    logic                   low_pulse_only_select;
    assign infrared_output_enable = ir_ctrl_ff[IRPWM_IRE_BIT];
    assign hf  = ir_ctrl_ff[IRPWM_HF_BIT];
    assign low_pulse_only_select = ir_ctrl_ff[IRPWM_LGP_BIT];
    // ****************************************************************
    // axi4-lite write channel
    // ****************************************************************
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign wr_go  = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_ofs = 8'(aw_addr_ff);
    assign wr_hit = (wr_ofs <= IRPWM_STATUS_OFS) && (wr_ofs[1:0] == 2'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_held_ff  <= 1'b0;
            w_data_ff  <= 32'h0;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= IRPWM_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_hit ? IRPWM_RESP_OKAY : IRPWM_RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // control and preset registers; only byte lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ir_ctrl_ff  <= IRPWM_CTRL_RST;
            cnt_ctrl_ff <= IRPWM_CTRL_RST;
            pt_ctrl_ff  <= IRPWM_CTRL_RST;
            car_pre_ff  <= IRPWM_PRE_RST;
            hi_pre_ff   <= IRPWM_PRE_RST;
            lo_pre_ff   <= IRPWM_PRE_RST;
            int_mask_ff <= '0;
        end else if (ce && wr_go && w_strb_ff[0]) begin
            unique case (wr_ofs)
                IRPWM_IR_CTRL_OFS:  ir_ctrl_ff  <= {5'h0, w_data_ff[2:0]};
                IRPWM_CNT_CTRL_OFS: cnt_ctrl_ff <= {4'h0, w_data_ff[3:0]};
                IRPWM_PT_CTRL_OFS:  pt_ctrl_ff  <= {4'h0, w_data_ff[3:0]};
                IRPWM_CAR_PRE_OFS:  car_pre_ff  <= w_data_ff[7:0];
                IRPWM_HI_PRE_OFS:   hi_pre_ff   <= w_data_ff[7:0];
                IRPWM_LO_PRE_OFS:   lo_pre_ff   <= w_data_ff[7:0];
                IRPWM_INT_MASK_OFS: int_mask_ff <= w_data_ff[IRPWM_EV_N-1:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // axi4-lite read channel
    // ****************************************************************
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign rd_ofs = 8'(s_axi_araddr);

    always_comb begin
        rd_val = 32'h0;
        rd_hit = 1'b1;
        unique case (rd_ofs)
            IRPWM_IR_CTRL_OFS:  rd_val = {24'h0, ir_ctrl_ff};
            IRPWM_CNT_CTRL_OFS: rd_val = {24'h0, cnt_ctrl_ff};
            IRPWM_PT_CTRL_OFS:  rd_val = {24'h0, pt_ctrl_ff};
            IRPWM_CAR_PRE_OFS:  rd_val = {24'h0, car_pre_ff};
            IRPWM_HI_PRE_OFS:   rd_val = {24'h0, hi_pre_ff};
            IRPWM_LO_PRE_OFS:   rd_val = {24'h0, lo_pre_ff};
            IRPWM_INT_STAT_OFS: rd_val = {29'h0, int_stat_ff};
            IRPWM_INT_MASK_OFS: rd_val = {29'h0, int_mask_ff};
            IRPWM_STATUS_OFS:   rd_val = {28'h0, phase_ff == IRPWM_LOW,
                                          phase_ff == IRPWM_HIGH,
                                          phase_ff != IRPWM_IDLE && !infrared_output_enable, out_ff};
            default:            rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0;
            rresp_ff  <= IRPWM_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= rd_val;
                rresp_ff  <= rd_hit ? IRPWM_RESP_OKAY : IRPWM_RESP_SLVERR;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // oscillator synchronisers and prescalers
    // ****************************************************************
    // oscillators are slow foreign clocks, sampled as levels; each must be
    // below half of aclk for every edge to be seen
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_s1_ff   <= 2'h0;
            osc_s2_ff   <= 2'h0;
            osc_prev_ff <= 2'h0;
        end else if (ce) begin
            osc_s1_ff   <= {sub_oscillator_clock, main_oscillator_clock};
            osc_s2_ff   <= osc_s1_ff;
            osc_prev_ff <= osc_s2_ff;
        end
    end
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_edge
            assign osc_edge[g] = osc_s2_ff[g] && !osc_prev_ff[g];
        end
    endgenerate
    function automatic logic psc_done(input logic [6:0] cnt, input logic [2:0] expo);
        psc_done = (cnt == 7'((8'h01 << expo) - 8'h01));
    endfunction
    assign car_tick = osc_edge[cnt_ctrl_ff[IRPWM_CSEL_BIT]]
                    && psc_done(car_psc_ff, cnt_ctrl_ff[IRPWM_PSC_LSB +: IRPWM_PSC_W]);
    assign pt_tick  = osc_edge[pt_ctrl_ff[IRPWM_CSEL_BIT]]
                    && psc_done(pt_psc_ff, pt_ctrl_ff[IRPWM_PSC_LSB +: IRPWM_PSC_W]);

    always_ff @(posedge aclk) begin
        if (!aresetn || (ce && phase_ff == IRPWM_IDLE)) begin
            car_psc_ff <= 7'h0;
            pt_psc_ff  <= 7'h0;
        end else if (ce) begin
            if (osc_edge[cnt_ctrl_ff[IRPWM_CSEL_BIT]])
                car_psc_ff <= car_tick ? 7'h0 : car_psc_ff + 7'h01;
            if (osc_edge[pt_ctrl_ff[IRPWM_CSEL_BIT]])
                pt_psc_ff <= pt_tick ? 7'h0 : pt_psc_ff + 7'h01;
        end
    end

    // ****************************************************************
    // carrier counter
    // ****************************************************************
    // no carrier events while the pin rests, else idle ticks would keep setting the flag
    assign car_uf = car_tick && car_cnt_ff == 8'h00 && phase_ff != IRPWM_IDLE;
    always_ff @(posedge aclk) begin
        if (!aresetn || (ce && phase_ff == IRPWM_IDLE)) begin
            car_cnt_ff  <= 8'h00;
            car_wave_ff <= 1'b0;
        end else if (ce && car_tick) begin
            if (car_uf) begin
                car_cnt_ff  <= car_pre_ff;
                car_wave_ff <= !car_wave_ff;
            end else begin
                car_cnt_ff <= car_cnt_ff - 8'h01;
            end
        end
    end

    // ****************************************************************
    // pulse-width timers and phase sequencer
    // ****************************************************************
    assign hi_uf = pt_tick && phase_ff == IRPWM_HIGH && hi_cnt_ff == 8'h00;
    assign lo_uf = pt_tick && phase_ff == IRPWM_LOW && lo_cnt_ff == 8'h00;

    always_comb begin
        nxt_phase = phase_ff;
        unique case (phase_ff)
            IRPWM_IDLE: if (infrared_output_enable) nxt_phase = low_pulse_only_select ? IRPWM_LOW : IRPWM_HIGH;
            IRPWM_HIGH: if (hi_uf) nxt_phase = infrared_output_enable ? IRPWM_LOW : IRPWM_IDLE;
            IRPWM_LOW:  if (lo_uf) nxt_phase = !low_pulse_only_select ? IRPWM_HIGH
                                             : (infrared_output_enable ? IRPWM_LOW : IRPWM_IDLE);
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_ff <= IRPWM_IDLE;
        end else if (ce) begin
            phase_ff <= nxt_phase;
        end
    end
    // each timer is loaded as its phase opens; in low-only mode the low timer also reloads on its own underflow
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hi_cnt_ff <= 8'h00;
            lo_cnt_ff <= 8'h00;
        end else if (ce) begin
            if (nxt_phase == IRPWM_HIGH && phase_ff != IRPWM_HIGH)
                hi_cnt_ff <= hi_pre_ff;
            else if (pt_tick && phase_ff == IRPWM_HIGH && !hi_uf)
                hi_cnt_ff <= hi_cnt_ff - 8'h01;
            if (nxt_phase == IRPWM_LOW && (phase_ff != IRPWM_LOW || lo_uf))
                lo_cnt_ff <= lo_pre_ff;
            else if (pt_tick && phase_ff == IRPWM_LOW && !lo_uf)
                lo_cnt_ff <= lo_cnt_ff - 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || (ce && phase_ff == IRPWM_IDLE)) begin
            lgp_tog_ff <= 1'b0;
        end else if (ce && lo_uf) begin
            lgp_tog_ff <= !lgp_tog_ff;
        end
    end

    // ****************************************************************
    // output pin
    // ****************************************************************
    always_comb begin
        nxt_out = 1'b0;
        unique case (phase_ff)
            IRPWM_IDLE: nxt_out = 1'b0;
            IRPWM_HIGH: nxt_out = !hf;
            IRPWM_LOW:  nxt_out = hf ? car_wave_ff : (low_pulse_only_select && lgp_tog_ff);
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_ff <= 1'b0;
        end else if (ce) begin
            out_ff <= nxt_out;
        end
    end
    assign infrared_output_pin = out_ff;
    // ****************************************************************
    // interrupts
    // ****************************************************************
    assign ev[IRPWM_EV_CAR] = car_uf;
    assign ev[IRPWM_EV_HI]  = hi_uf;
    assign ev[IRPWM_EV_LO]  = lo_uf;
    // a new event in the cycle of its write-one clear stays set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_stat_ff <= '0;
        end else if (ce) begin
            if (wr_go && w_strb_ff[0] && wr_ofs == IRPWM_INT_STAT_OFS)
                int_stat_ff <= (int_stat_ff & ~w_data_ff[IRPWM_EV_N-1:0]) | ev;
            else
                int_stat_ff <= int_stat_ff | ev;
        end
    end
    assign irq = |(int_stat_ff & int_mask_ff);
endmodule // irpwm_top
`default_nettype wire

// *** tb/irpwm_assertions.sv ***
// checker: bus handshake and output properties of the ir carrier / pwm block
`timescale 1ns/1ps
`default_nettype none
module irpwm_chk
    import irpwm_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        infrared_output_pin,
    input wire logic        irq
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_quiet: assert property (
        disable iff (1'b0) !aresetn |=> !infrared_output_pin && !irq)
        else $error("pin or irq active after reset");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // both halves are held one edge after they are taken, the answer one edge later
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_pin_min_run: assert property ($rose(infrared_output_pin) |=> infrared_output_pin)
        else $error("pin pulse shorter than a tick");
    cover property ($rose(irq));
    cover property ($rose(infrared_output_pin));
    cover property (s_axi_rvalid && s_axi_rresp == IRPWM_RESP_SLVERR);
endmodule // irpwm_chk
bind irpwm_top irpwm_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .infrared_output_pin(infrared_output_pin), .irq(irq));
`default_nettype wire

// *** tb/irpwm_load.sv ***
// partner: emitter load that measures the longest high and low runs on the pin
`timescale 1ns/1ps
`default_nettype none
module irpwm_load (
    input wire logic         aclk,
    input wire logic         aresetn,
    input wire logic         pin,
    input wire logic         clr,
    output logic [15:0]      hi_max_ff,
    output logic [15:0]      lo_max_ff
);
    logic [15:0] run_ff;
    logic        last_ff;
    // the run in progress at clear time is cut short, so it never inflates a maximum
    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            run_ff    <= 16'h0000;
            last_ff   <= pin;
            hi_max_ff <= 16'h0000;
            lo_max_ff <= 16'h0000;
        end else if (pin == last_ff) begin
            run_ff <= run_ff + 16'h0001;
        end else begin
            if (last_ff && run_ff > hi_max_ff) hi_max_ff <= run_ff;
            if (!last_ff && run_ff > lo_max_ff) lo_max_ff <= run_ff;
            run_ff  <= 16'h0001;
            last_ff <= pin;
        end
    end
endmodule // irpwm_load
`default_nettype wire

// *** tb/tb.sv ***
// testbench: register, waveform, drain and interrupt scenarios of the ir pwm block
`timescale 1ns/1ps
`default_nettype none
module tb
    import irpwm_pkg::*;
;
    logic        aclk = 1'b0, aresetn = 1'b0, osc_m = 1'b0, osc_s = 1'b0, clr = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awready, wready, bvalid, arready, rvalid, pin, irq;
    logic [1:0]  bresp, rresp, bresp_seen;
    logic [15:0] hi_max, lo_max;
    logic [7:0]  cfg [3] = '{8'h00, 8'h02, 8'h01};
    int          per [3] = '{8, 16, 12};
    int          fail_count = 0, num_checks = 0, cyc = 0;
    // ****************************************************************
    // clocks, design and load
    // ****************************************************************
    always #5 aclk = ~aclk;
    // oscillators are derived from aclk so tick spacing is exact: 8 and 12 aclk periods
    always @(posedge aclk) begin
        cyc   <= cyc + 1;
        osc_m <= (cyc % 8) < 4;
        osc_s <= (cyc % 12) < 6;
        if (cyc == 60000) begin
            fail_count++;
            close_out();
        end
    end
    irpwm_top dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .main_oscillator_clock(osc_m),
        .sub_oscillator_clock(osc_s), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .infrared_output_pin(pin), .irq(irq));
    irpwm_load u_load (.aclk(aclk), .aresetn(aresetn), .pin(pin), .clr(clr),
        .hi_max_ff(hi_max), .lo_max_ff(lo_max));
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic close_out;
        if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // handshakes are judged at the negedge, where the values of the coming edge are settled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic pa, pw, pb, ta, tw, tk;
        @(posedge aclk);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        pa = 1'b1; pw = 1'b1; pb = 1'b1;
        while (pa || pw || pb) begin
            @(negedge aclk);
            ta = pa && awready; tw = pw && wready; tk = pb && bvalid;
            if (tk) bresp_seen = bresp;
            @(posedge aclk);
            if (ta) begin awvalid <= 1'b0; pa = 1'b0; end
            if (tw) begin wvalid <= 1'b0; pw = 1'b0; end
            if (tk) begin bready <= 1'b0; pb = 1'b0; end
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic pa, pr, ta, tr;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        pa = 1'b1; pr = 1'b1;
        while (pa || pr) begin
            @(negedge aclk);
            ta = pa && arready; tr = pr && rvalid;
            if (tr) begin d = rdata; r = rresp; end
            @(posedge aclk);
            if (ta) begin arvalid <= 1'b0; pa = 1'b0; end
            if (tr) begin rready <= 1'b0; pr = 1'b0; end
        end
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(nm, exp, d & m);
    endtask
    task automatic irq_is(input logic exp);
        @(negedge aclk);
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask
    task automatic measure(input int n);
        @(posedge aclk); clr <= 1'b1;
        @(posedge aclk); clr <= 1'b0;
        repeat (n) @(posedge aclk);
        // the load updates its maxima on the edge; read them once settled
        @(negedge aclk);
    endtask
    task automatic run(input logic [7:0] ctl);
        wr(IRPWM_IR_CTRL_OFS, ctl);
        repeat (300) @(posedge aclk);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0]  r;
        rchk("hi_pre_rst", IRPWM_HI_PRE_OFS, 32'hFF, 32'hFF);
        rchk("ctrl_rst", IRPWM_IR_CTRL_OFS, 32'hFFFFFFFF, 32'h0);
        rd(8'h24, d, r);
        chk("unmapped_resp", {30'h0, IRPWM_RESP_SLVERR}, {30'h0, r});
        chk("unmapped_data", 32'h0, d);
        wr(8'h24, 8'h5A);
        chk("unmapped_bresp", {30'h0, IRPWM_RESP_SLVERR}, {30'h0, bresp_seen});
        wr(IRPWM_CAR_PRE_OFS, 8'h5A);
        chk("mapped_bresp", {30'h0, IRPWM_RESP_OKAY}, {30'h0, bresp_seen});
        rchk("car_pre_rw", IRPWM_CAR_PRE_OFS, 32'hFFFFFFFF, 32'h5A);
    endtask
    task automatic t_pwm;
        wr(IRPWM_HI_PRE_OFS, 8'h02);
        wr(IRPWM_LO_PRE_OFS, 8'h04);
        for (int i = 0; i < 3; i++) begin
            wr(IRPWM_PT_CTRL_OFS, cfg[i]);
            run(8'h01);
            measure(400);
            chk("pwm_high", 32'(3 * per[i]), {16'h0, hi_max});
            chk("pwm_low", 32'(5 * per[i]), {16'h0, lo_max});
            run(8'h00);
        end
        wr(IRPWM_PT_CTRL_OFS, 8'h00);
    endtask
    task automatic t_carrier;
        wr(IRPWM_CAR_PRE_OFS, 8'h01);
        wr(IRPWM_HI_PRE_OFS, 8'h00);
        wr(IRPWM_LO_PRE_OFS, 8'h0F);
        for (int i = 0; i < 3; i++) begin
            wr(IRPWM_CNT_CTRL_OFS, cfg[i]);
            run(8'h03);
            measure(400);
            chk("carrier_half", 32'(2 * per[i]), {16'h0, hi_max});
            run(8'h00);
        end
    endtask
    task automatic t_irq;
        wr(IRPWM_INT_MASK_OFS, 8'h00);
        irq_is(1'b0);
        wr(IRPWM_INT_MASK_OFS, 8'h01);
        irq_is(1'b1);
        wr(IRPWM_INT_STAT_OFS, 8'h01);
        rchk("stat_w1c", IRPWM_INT_STAT_OFS, 32'h07, 32'h06);
        irq_is(1'b0);
        wr(IRPWM_INT_MASK_OFS, 8'h02);
        irq_is(1'b1);
        wr(IRPWM_INT_MASK_OFS, 8'h04);
        irq_is(1'b1);
        wr(IRPWM_INT_STAT_OFS, 8'h07);
        irq_is(1'b0);
    endtask
    task automatic t_lowonly;
        wr(IRPWM_HI_PRE_OFS, 8'h02);
        wr(IRPWM_LO_PRE_OFS, 8'h04);
        run(8'h05);
        measure(400);
        chk("low_only_high", 32'd40, {16'h0, hi_max});
        chk("low_only_low", 32'd40, {16'h0, lo_max});
        run(8'h00);
    endtask
    task automatic t_drain;
        run(8'h01);
        for (int n = 0; n < 200 && pin !== 1'b1; n++) @(posedge aclk);
        for (int n = 0; n < 200 && pin !== 1'b0; n++) @(posedge aclk);
        wr(IRPWM_IR_CTRL_OFS, 8'h00);
        measure(150);
        chk("drain_high", 32'd24, {16'h0, hi_max});
        measure(200);
        chk("rest_high", 32'd0, {16'h0, hi_max});
        chk("rest_pin", 32'd0, {31'h0, pin});
        rchk("drain_flag", IRPWM_STATUS_OFS, 32'h02, 32'h0);
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_pwm();
        t_carrier();
        t_irq();
        t_lowonly();
        t_drain();
        close_out();
    end
endmodule // tb
`default_nettype wire
